// File: pcfc_regs.sv
// management register slice: fault counters and device configuration
// Functional notes
// (RL1) local fault events count in upper byte
// (RL2) remote fault events count in lower byte
// (RL3) counters stick at maximum, never wrap
// (RL4) reading counter register returns then clears counts
// (RL5) link control disable keeps counter values
// (RL6) strap pins give reset values of fields
// (RL7) hookup bit joins ports internally or externally
// (RL8) clock mode field picks clock source
// (RL9) supply bit picks internal or external core
// (RL10) clock drive bit reduces output strength
// (RL11) clock hold keeps clocks until forced sleep
// (RL12) wake timer field sets wake filter time
// (RL13) inhibit bit keeps inhibit on when disabled
// (RL14) common register only in port zero block
// (RL15) polarity bit swaps line pins of ports
// (RL16) forced sleep write sleeps both ports, self-clears
// (RL17) port one forced sleep reads zero
// (RL18) latched events hold until read clears
// (RL19) event during clearing read is still counted
// (RL20) reserved bits read zero, writes ignored
`timescale 1ns/1ps
module pcfc_regs
  import pcfc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // serial management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // strap pins, sampled after reset
  input wire logic strap_autonomous_i,
  input wire logic strap_hookup_i,
  input wire logic [1:0] strap_clk_mode_i,
  input wire logic strap_core_supply_i,
  input wire logic [1:0] strap_port_enable_i,
  // receiver fault events per port, one-cycle pulses
  input wire logic [1:0] local_fault_i,
  input wire logic [1:0] remote_fault_i,
  input wire logic link_control_en_i,
  // power state inputs
  input wire logic [1:0] clk_needed_i,
  input wire logic system_wake_i,
  input wire logic disable_mode_i,
  input wire logic inhibit_request_i,
  // configuration outputs
  output logic autonomous_select_o,
  output logic port_hookup_o,
  output logic [1:0] clk_mode_o,
  output logic core_supply_sel_o,
  output logic clk_drive_reduced_o,
  output logic clk_hold_o,
  output logic [1:0] wake_filter_time_o,
  output logic wake_ratiometric_o,
  output logic inhibit_in_disable_o,
  output logic line_polarity_swap_o,
  output logic [1:0] port_enable_o,
  // power control outputs
  output logic force_sleep_o,
  output logic sleep_commanded_o,
  output logic clock_run_o,
  output logic inhibit_output_o,
  // counters, for observation
  output logic [7:0] local_fault_count_o [2],
  output logic [7:0] remote_fault_count_o [2]
);
  logic mdc_s, mdio_s, mdc_prev_q, mdc_rise;
  logic [6:0] strap_s;
  logic strap_pend_q, is_read_q, port_sel_q;
  pcfc_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [5:0] ones_q;
  logic [12:0] hdr_q;
  logic [13:0] hdr_full;
  logic [4:0] reg_q;
  logic [15:0] shift_q, rd_data, wr_data;
  logic wr_commit, rd_latch, hdr_match, hdr_port;
  logic [1:0] cnt_clr;

  // pins cross into the clock domain before any use
  pcfc_sync2 #(.WIDTH(2)) u_sync_mgmt (
    .sys_clk_i(sys_clk_i),
    .async_i({mdc_i, mdio_i}),
    .sync_o({mdc_s, mdio_s})
  );

  pcfc_sync2 #(.WIDTH(7)) u_sync_strap (
    .sys_clk_i(sys_clk_i),
    .async_i({strap_autonomous_i, strap_hookup_i, strap_clk_mode_i,
              strap_core_supply_i, strap_port_enable_i}),
    .sync_o(strap_s)
  );

  // mdc edge found on the settled copy only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end
  assign mdc_rise = mdc_s && !mdc_prev_q;

  // header decode of the fourteen start, op, address bits
  assign hdr_full = {hdr_q, mdio_s};
  assign hdr_port = (hdr_full[9:5] == PCFC_PHYAD_PORT_ONE);
  assign hdr_match = (hdr_full[13:12] == PCFC_FRAME_START) &&
                     (hdr_full[11:10] == PCFC_OP_READ || hdr_full[11:10] == PCFC_OP_WRITE) &&
                     (hdr_full[9:5] == PCFC_PHYAD_PORT_ZERO || hdr_port);

  // frame receiver; unmatched frames fall back to preamble hunt
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= PCFC_ST_PRE;
      bit_cnt_q <= 4'h0;
      ones_q <= 6'h00;
      hdr_q <= 13'h0000;
      is_read_q <= 1'b0;
      port_sel_q <= 1'b0;
      reg_q <= 5'h00;
    end else if (mdc_rise) begin
      case (state_q)
        PCFC_ST_PRE: begin
          if (mdio_s) begin
            ones_q <= (ones_q == PCFC_PRE_LEN) ? ones_q : ones_q + 6'h01;
          end else begin
            ones_q <= 6'h00;
            if (ones_q == PCFC_PRE_LEN) begin
              state_q <= PCFC_ST_HDR;
              hdr_q <= 13'h0000;
              bit_cnt_q <= 4'h1;
            end
          end
        end
        PCFC_ST_HDR: begin
          hdr_q <= hdr_full[12:0];
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == PCFC_HDR_LAST) begin
            state_q <= hdr_match ? PCFC_ST_TA : PCFC_ST_PRE;
            is_read_q <= (hdr_full[11:10] == PCFC_OP_READ);
            port_sel_q <= hdr_port;
            reg_q <= hdr_full[4:0];
            bit_cnt_q <= 4'h0;
          end
        end
        PCFC_ST_TA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'h1) begin
            state_q <= is_read_q ? PCFC_ST_RD : PCFC_ST_WR;
            bit_cnt_q <= 4'h0;
          end
        end
        PCFC_ST_RD, PCFC_ST_WR: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == PCFC_DATA_LAST) begin
            state_q <= PCFC_ST_PRE;
            bit_cnt_q <= 4'h0;
          end
        end
        default: state_q <= PCFC_ST_PRE;
      endcase
    end
  end

  // read data latched at end of turnaround
  assign rd_latch = mdc_rise && state_q == PCFC_ST_TA && bit_cnt_q == 4'h1 && is_read_q;
  assign wr_commit = mdc_rise && state_q == PCFC_ST_WR && bit_cnt_q == PCFC_DATA_LAST;
  assign wr_data = {shift_q[14:0], mdio_s};

  // data shifter and pin drive; device drives from second turnaround bit
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shift_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (mdc_rise) begin
      if (state_q == PCFC_ST_TA && bit_cnt_q == 4'h0 && is_read_q) begin
        mdio_o <= 1'b0;
        mdio_oe_o <= 1'b1;
      end else if (rd_latch) begin
        shift_q <= rd_data;
        mdio_o <= rd_data[15];
      end else if (state_q == PCFC_ST_RD) begin
        shift_q <= {shift_q[14:0], 1'b0};
        mdio_o <= shift_q[14];
        mdio_oe_o <= (bit_cnt_q != PCFC_DATA_LAST);
      end else if (state_q == PCFC_ST_WR) begin
        shift_q <= wr_data;
      end
    end
  end

  // read mux per port block; reserved and unmapped bits are zero
  always_comb begin
    rd_data = 16'h0000; // RL20
    case (reg_q)
      PCFC_REG_FAULT_CNT: begin
        rd_data = {local_fault_count_o[port_sel_q], remote_fault_count_o[port_sel_q]};
      end
      PCFC_REG_COMMON_CFG: begin
        if (!port_sel_q) begin // RL14
          rd_data[PCFC_AUTO_BIT] = autonomous_select_o;
          rd_data[PCFC_HOOKUP_BIT] = port_hookup_o;
          rd_data[PCFC_CLKMODE_LSB +: 2] = clk_mode_o;
          rd_data[PCFC_SUPPLY_BIT] = core_supply_sel_o;
          rd_data[PCFC_CLKDRV_BIT] = clk_drive_reduced_o;
          rd_data[PCFC_CLKHOLD_BIT] = clk_hold_o;
          rd_data[PCFC_WAKETIM_LSB +: 2] = wake_filter_time_o;
          rd_data[PCFC_WAKECFG_BIT] = wake_ratiometric_o;
          rd_data[PCFC_INHCFG_BIT] = inhibit_in_disable_o;
        end
      end
      PCFC_REG_CFG_THREE: begin
        // self-clearing sleep bit always reads zero in both blocks
        rd_data[PCFC_SLEEP_BIT] = 1'b0; // RL17
        rd_data[PCFC_POL_BIT] = line_polarity_swap_o;
        rd_data[PCFC_EN_BIT] = port_enable_o[port_sel_q];
      end
      default: rd_data = 16'h0000;
    endcase
  end

  // clear-on-read pulse for the addressed block only
  assign cnt_clr[0] = rd_latch && reg_q == PCFC_REG_FAULT_CNT && !port_sel_q;
  assign cnt_clr[1] = rd_latch && reg_q == PCFC_REG_FAULT_CNT && port_sel_q;

  // counts survive link control disable; a read or reset are the only clears
  for (genvar p = 0; p < 2; p++) begin : g_port
    pcfc_sat_counter u_local (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .inc_i(local_fault_i[p]),
      .clr_i(cnt_clr[p]),
      .count_o(local_fault_count_o[p])
    ); // RL1 RL18
    pcfc_sat_counter u_remote (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .inc_i(remote_fault_i[p]),
      .clr_i(cnt_clr[p]),
      .count_o(remote_fault_count_o[p])
    ); // RL2
  end

  // strap capture one edge after release, once the synchroniser is settled
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
    end
  end

  // configuration fields; writes to port one common block are dropped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      autonomous_select_o <= 1'b0;
      port_hookup_o <= 1'b0;
      clk_mode_o <= 2'h0;
      core_supply_sel_o <= 1'b0;
      port_enable_o <= 2'h0;
      clk_drive_reduced_o <= PCFC_CLKDRV_RST; // RL10
      clk_hold_o <= PCFC_CLKHOLD_RST;
      wake_filter_time_o <= PCFC_WAKETIM_RST; // RL12
      wake_ratiometric_o <= PCFC_WAKECFG_RST;
      inhibit_in_disable_o <= PCFC_INHCFG_RST;
      line_polarity_swap_o <= PCFC_POL_RST; // RL15
    end else if (strap_pend_q) begin
      {autonomous_select_o, port_hookup_o, clk_mode_o,
       core_supply_sel_o, port_enable_o} <= strap_s; // RL6
    end else if (wr_commit) begin
      if (reg_q == PCFC_REG_COMMON_CFG && !port_sel_q) begin // RL14
        autonomous_select_o <= wr_data[PCFC_AUTO_BIT];
        port_hookup_o <= wr_data[PCFC_HOOKUP_BIT]; // RL7
        clk_mode_o <= wr_data[PCFC_CLKMODE_LSB +: 2]; // RL8
        core_supply_sel_o <= wr_data[PCFC_SUPPLY_BIT]; // RL9
        clk_drive_reduced_o <= wr_data[PCFC_CLKDRV_BIT];
        clk_hold_o <= wr_data[PCFC_CLKHOLD_BIT];
        wake_filter_time_o <= wr_data[PCFC_WAKETIM_LSB +: 2];
        wake_ratiometric_o <= wr_data[PCFC_WAKECFG_BIT];
        inhibit_in_disable_o <= wr_data[PCFC_INHCFG_BIT];
      end
      if (reg_q == PCFC_REG_CFG_THREE) begin
        line_polarity_swap_o <= wr_data[PCFC_POL_BIT]; // RL15
        port_enable_o[port_sel_q] <= wr_data[PCFC_EN_BIT];
      end
    end
  end

  // forced sleep exists only in port zero; pulse plus sticky request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      force_sleep_o <= 1'b0;
      sleep_commanded_o <= 1'b0;
    end else begin
      force_sleep_o <= wr_commit && reg_q == PCFC_REG_CFG_THREE && !port_sel_q &&
                       wr_data[PCFC_SLEEP_BIT]; // RL16
      if (force_sleep_o) begin
        sleep_commanded_o <= 1'b1; // RL16
      end else if (system_wake_i) begin
        sleep_commanded_o <= 1'b0;
      end
    end
  end

  // clock gating and inhibit drive; hold trades power for clock availability
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clock_run_o <= 1'b1;
      inhibit_output_o <= 1'b0;
    end else begin
      clock_run_o <= clk_hold_o ? !sleep_commanded_o : |clk_needed_i; // RL11
      inhibit_output_o <= disable_mode_i ? inhibit_in_disable_o : inhibit_request_i; // RL13
    end
  end

  chk_port_one_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL14
    (port_sel_q && reg_q == PCFC_REG_COMMON_CFG) |-> rd_data == 16'h0000)
    else $error("port one common register not zero");
  chk_sleep_reads_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL17
    (reg_q == PCFC_REG_CFG_THREE) |-> rd_data[15:3] == 13'h0000 && !rd_data[1])
    else $error("sleep or reserved bit read nonzero");
  chk_reserved_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL20
    (reg_q == PCFC_REG_COMMON_CFG) |-> rd_data[4:0] == 5'h00)
    else $error("reserved common bits nonzero");
  chk_sleep_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL16
    force_sleep_o |=> !force_sleep_o && sleep_commanded_o)
    else $error("forced sleep not self-clearing");
  chk_inhibit_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL13
    disable_mode_i |=> inhibit_output_o == $past(inhibit_in_disable_o))
    else $error("inhibit wrong in disable mode");
  chk_clock_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL11
    (!clk_hold_o && clk_needed_i == 2'h0) |=> !clock_run_o)
    else $error("clock kept running while unneeded");
  chk_hookup_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL7
    (wr_commit && reg_q == PCFC_REG_COMMON_CFG && !port_sel_q)
      |=> port_hookup_o == $past(wr_data[PCFC_HOOKUP_BIT]))
    else $error("hookup bit not written");
  chk_count_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL4
    (cnt_clr[0] && !local_fault_i[0]) |=> local_fault_count_o[0] == PCFC_CNT_RST)
    else $error("read did not clear local count");
  chk_keep_link_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL5
    (!link_control_en_i && !cnt_clr[1] && !remote_fault_i[1])
      |=> $stable(remote_fault_count_o[1]))
    else $error("count changed while link control off");
endmodule : pcfc_regs

// File: pcfc_pkg.sv
// constants for the phy configuration and fail counter register slice
package pcfc_pkg;
  // register addresses inside each port block
  localparam logic [4:0] PCFC_REG_FAULT_CNT = 5'h1A;
  localparam logic [4:0] PCFC_REG_COMMON_CFG = 5'h1B;
  localparam logic [4:0] PCFC_REG_CFG_THREE = 5'h1C;
  // management addresses of the two port blocks
  localparam logic [4:0] PCFC_PHYAD_PORT_ZERO = 5'h04;
  localparam logic [4:0] PCFC_PHYAD_PORT_ONE = 5'h05;
  // field positions, common configuration
  localparam int PCFC_AUTO_BIT = 15;
  localparam int PCFC_HOOKUP_BIT = 14;
  localparam int PCFC_CLKMODE_LSB = 12;
  localparam int PCFC_SUPPLY_BIT = 11;
  localparam int PCFC_CLKDRV_BIT = 10;
  localparam int PCFC_CLKHOLD_BIT = 9;
  localparam int PCFC_WAKETIM_LSB = 7;
  localparam int PCFC_WAKECFG_BIT = 6;
  localparam int PCFC_INHCFG_BIT = 5;
  // field positions, configuration three
  localparam int PCFC_POL_BIT = 2;
  localparam int PCFC_SLEEP_BIT = 1;
  localparam int PCFC_EN_BIT = 0;
  // values after reset of fields not taken from straps, and the counter ceiling
  localparam logic PCFC_CLKDRV_RST = 1'b0;
  localparam logic PCFC_CLKHOLD_RST = 1'b0;
  localparam logic [1:0] PCFC_WAKETIM_RST = 2'h0;
  localparam logic PCFC_WAKECFG_RST = 1'b1;
  localparam logic PCFC_INHCFG_RST = 1'b0;
  localparam logic PCFC_POL_RST = 1'b0;
  localparam logic [7:0] PCFC_CNT_RST = 8'h00;
  localparam logic [7:0] PCFC_CNT_MAX = 8'hFF;
  // management frame layout
  localparam logic [5:0] PCFC_PRE_LEN = 6'h20;
  localparam logic [1:0] PCFC_FRAME_START = 2'h1;
  localparam logic [1:0] PCFC_OP_READ = 2'h2;
  localparam logic [1:0] PCFC_OP_WRITE = 2'h1;
  localparam logic [3:0] PCFC_HDR_LAST = 4'hD;
  localparam logic [3:0] PCFC_DATA_LAST = 4'hF;
  // frame receiver states
  typedef enum logic [4:0] {
    PCFC_ST_PRE = 5'h01,
    PCFC_ST_HDR = 5'h02,
    PCFC_ST_TA = 5'h04,
    PCFC_ST_RD = 5'h08,
    PCFC_ST_WR = 5'h10
  } pcfc_state_t;
endpackage : pcfc_pkg

// File: pcfc_sync2.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pcfc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic sys_clk_i,
  // asynchronous side and synchronised side
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end
endmodule : pcfc_sync2

// File: pcfc_sat_counter.sv
// saturating clear-on-read fault counter
`timescale 1ns/1ps
module pcfc_sat_counter
  import pcfc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // events and clear
  input wire logic inc_i,
  input wire logic clr_i,
  // count
  output logic [7:0] count_o
);
  logic [7:0] base;

  // clear first, so an event in the clearing cycle still counts
  always_comb begin
    base = clr_i ? PCFC_CNT_RST : count_o; // RL4 RL19
  end

  // counter state; link control has no say here
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_o <= PCFC_CNT_RST; // RL5
    end else if (inc_i && base != PCFC_CNT_MAX) begin
      count_o <= base + 8'h01; // RL1 RL2
    end else begin
      count_o <= base; // RL3
    end
  end

  chk_sat_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL3
    (count_o == PCFC_CNT_MAX && !clr_i) |=> count_o == PCFC_CNT_MAX)
    else $error("counter left saturation without clear");
  chk_clear_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL4
    (clr_i && !inc_i) |=> count_o == PCFC_CNT_RST)
    else $error("counter not cleared by read");
  chk_clear_inc: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL19
    (clr_i && inc_i) |=> count_o == 8'h01)
    else $error("event lost at clearing read");
  chk_count_step: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL1
    (inc_i && !clr_i && count_o != PCFC_CNT_MAX) |=> count_o == $past(count_o) + 8'h01)
    else $error("counter did not step on event");
endmodule : pcfc_sat_counter

// File: pcfc_mdio_host.sv
// management host model that sends clause-22 frames to the register slice
`timescale 1ns/1ps
module pcfc_mdio_host
  import pcfc_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // resolved management data line
  input wire logic mdio_i,
  // host drive of the management pins
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  // mdc is sys_clk/10, well below the synchroniser limit
  localparam int HALF = 5;

  // mdc stands low outside frames and the line is released
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // one whole frame; read data is taken on the rises after turnaround
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rga,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta_low);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, PCFC_FRAME_START, op, phy, rga, 2'h2, wd};
    rd = 16'h0000;
    ta_low = 1'b0;
    @(negedge sys_clk_i);
    for (int i = 0; i < 64; i++) begin
      mdc_o <= 1'b0;
      // host lets go for turnaround and data of a read
      mdio_oe_o <= !(op == PCFC_OP_READ && i >= 46);
      mdio_o <= bits[63-i];
      repeat (HALF) @(negedge sys_clk_i);
      mdc_o <= 1'b1;
      if (i == 47) ta_low = (mdio_i === 1'b0);
      if (i >= 48) rd = {rd[14:0], mdio_i};
      repeat (HALF) @(negedge sys_clk_i);
    end
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
  endtask : frame
endmodule : pcfc_mdio_host

// File: pcfc_regs_tb.sv
// self-checking bench for the configuration and fault counter slice
`timescale 1ns/1ps
module pcfc_regs_tb;
  import pcfc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] straps = 7'h55;
  logic mdc_i, mdio_i, mdio_o, mdio_oe_o, h_oe, h_dat;
  logic link_control_en_i = 1'b1;
  logic system_wake_i = 1'b0;
  logic disable_mode_i = 1'b0;
  logic inhibit_request_i = 1'b0;
  logic [1:0] clk_needed_i = 2'h0;
  logic [1:0] local_fault_i = 2'h0;
  logic [1:0] remote_fault_i = 2'h0;
  logic autonomous_select_o, port_hookup_o, core_supply_sel_o, clk_drive_reduced_o;
  logic clk_hold_o, wake_ratiometric_o, inhibit_in_disable_o, line_polarity_swap_o;
  logic force_sleep_o, sleep_commanded_o, clock_run_o, inhibit_output_o;
  logic [1:0] clk_mode_o, wake_filter_time_o, port_enable_o;
  logic [7:0] local_fault_count_o [2];
  logic [7:0] remote_fault_count_o [2];
  logic [15:0] cfg_vec, rdat;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int fs_cnt = 0;

  // clock, pull-up on the shared line, config outputs packed as in the register
  always #20 sys_clk_i = !sys_clk_i;
  assign mdio_i = mdio_oe_o ? mdio_o : (h_oe ? h_dat : 1'b1);
  assign cfg_vec = {autonomous_select_o, port_hookup_o, clk_mode_o, core_supply_sel_o,
                    clk_drive_reduced_o, clk_hold_o, wake_filter_time_o, wake_ratiometric_o,
                    inhibit_in_disable_o, 5'h00};

  // straps first: autonomous, external hookup, clock mode 10, external core, port zero on
  pcfc_regs i_pcfc_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mdc_i(mdc_i), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .strap_autonomous_i(straps[6]),
    .strap_hookup_i(straps[5]), .strap_clk_mode_i(straps[4:3]), .strap_core_supply_i(straps[2]),
    .strap_port_enable_i(straps[1:0]),
    .local_fault_i(local_fault_i), .remote_fault_i(remote_fault_i),
    .link_control_en_i(link_control_en_i), .clk_needed_i(clk_needed_i),
    .system_wake_i(system_wake_i), .disable_mode_i(disable_mode_i),
    .inhibit_request_i(inhibit_request_i), .autonomous_select_o(autonomous_select_o),
    .port_hookup_o(port_hookup_o), .clk_mode_o(clk_mode_o), .core_supply_sel_o(core_supply_sel_o),
    .clk_drive_reduced_o(clk_drive_reduced_o), .clk_hold_o(clk_hold_o),
    .wake_filter_time_o(wake_filter_time_o), .wake_ratiometric_o(wake_ratiometric_o),
    .inhibit_in_disable_o(inhibit_in_disable_o), .line_polarity_swap_o(line_polarity_swap_o),
    .port_enable_o(port_enable_o), .force_sleep_o(force_sleep_o),
    .sleep_commanded_o(sleep_commanded_o), .clock_run_o(clock_run_o),
    .inhibit_output_o(inhibit_output_o), .local_fault_count_o(local_fault_count_o),
    .remote_fault_count_o(remote_fault_count_o));

  pcfc_mdio_host i_pcfc_mdio_host (.sys_clk_i(sys_clk_i), .mdio_i(mdio_i), .mdc_o(mdc_i),
    .mdio_o(h_dat), .mdio_oe_o(h_oe));

  // cycle count for the hang limit, and cycles with the sleep pulse high
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (force_sleep_o === 1'b1) fs_cnt <= fs_cnt + 1;
    if (cyc == 40000) begin
      fail_count++;
      $display("ERROR %0t run exceeded its cycle limit", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a read also checks that the device pulls turnaround low and lets go after
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] d);
    logic ta;
    i_pcfc_mdio_host.frame(PCFC_OP_READ, phy, ra, 16'h0000, d, ta);
    chk({14'h0000, ta, mdio_oe_o}, 16'h0002);
  endtask : rd

  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    logic ta;
    i_pcfc_mdio_host.frame(PCFC_OP_WRITE, phy, ra, wd, d, ta);
  endtask : wr

  task automatic pulse(input logic [1:0] loc, input logic [1:0] rem, input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      local_fault_i = loc;
      remote_fault_i = rem;
      @(negedge sys_clk_i);
      local_fault_i = 2'h0;
      remote_fault_i = 2'h0;
    end
  endtask : pulse

  task automatic t_reset();
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, rdat);
    chk(rdat, 16'hA840);
    chk(cfg_vec, 16'hA840);
    chk({14'h0000, port_enable_o}, 16'h0001);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_CFG_THREE, rdat);
    chk(rdat, 16'h0001);
    rd(PCFC_PHYAD_PORT_ONE, PCFC_REG_CFG_THREE, rdat);
    chk(rdat, 16'h0000);
  endtask : t_reset

  // counts, clear on read, and a write to the counter register is dropped
  task automatic t_counters();
    pulse(2'h1, 2'h0, 3);
    pulse(2'h0, 2'h1, 5);
    pulse(2'h2, 2'h0, 2);
    chk({8'h00, local_fault_count_o[0]}, 16'h0003);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_FAULT_CNT, rdat);
    chk(rdat, 16'h0305);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_FAULT_CNT, rdat);
    chk(rdat, 16'h0000);
    rd(PCFC_PHYAD_PORT_ONE, PCFC_REG_FAULT_CNT, rdat);
    chk(rdat, 16'h0200);
    pulse(2'h1, 2'h0, 1);
    wr(PCFC_PHYAD_PORT_ZERO, PCFC_REG_FAULT_CNT, 16'h0000);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_FAULT_CNT, rdat);
    chk(rdat, 16'h0100);
  endtask : t_counters

  // more events than the counter holds, with link control off
  task automatic t_saturate();
    link_control_en_i = 1'b0;
    pulse(2'h2, 2'h2, 300);
    rd(PCFC_PHYAD_PORT_ONE, PCFC_REG_FAULT_CNT, rdat);
    chk(rdat, 16'hFFFF);
    link_control_en_i = 1'b1;
  endtask : t_saturate

  // every code of every common configuration field, reserved bits written as ones
  task automatic t_config();
    logic [1:0] k;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      w = {k[0], k[1], k, k[1], k[0], k[0], k, k[1], k[0], 5'h1F};
      wr(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, w);
      rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, rdat);
      chk(rdat, w & 16'hFFE0);
      chk(cfg_vec, w & 16'hFFE0);
    end
  endtask : t_config

  // port one and foreign addresses leave port zero alone
  task automatic t_port_one();
    wr(PCFC_PHYAD_PORT_ONE, PCFC_REG_COMMON_CFG, 16'h0000);
    wr(5'h07, PCFC_REG_COMMON_CFG, 16'h0000);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, rdat);
    chk(rdat, 16'hFFE0);
    rd(PCFC_PHYAD_PORT_ONE, PCFC_REG_COMMON_CFG, rdat);
    chk(rdat, 16'h0000);
    rd(PCFC_PHYAD_PORT_ZERO, 5'h10, rdat);
    chk(rdat, 16'h0000);
    wr(PCFC_PHYAD_PORT_ZERO, PCFC_REG_CFG_THREE, 16'hFFF9);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_CFG_THREE, rdat);
    chk(rdat, 16'h0001);
  endtask : t_port_one

  // clock hold is set here, so the clock must stop once sleep is commanded
  task automatic t_sleep();
    int fs0;
    fs0 = fs_cnt;
    wr(PCFC_PHYAD_PORT_ZERO, PCFC_REG_CFG_THREE, 16'h0007);
    repeat (4) @(negedge sys_clk_i);
    chk(16'(fs_cnt - fs0), 16'h0001);
    chk({14'h0000, sleep_commanded_o, clock_run_o}, 16'h0002);
    chk({15'h0000, line_polarity_swap_o}, 16'h0001);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_CFG_THREE, rdat);
    chk(rdat, 16'h0005);
    rd(PCFC_PHYAD_PORT_ONE, PCFC_REG_CFG_THREE, rdat);
    chk(rdat, 16'h0004);
    system_wake_i = 1'b1;
    @(negedge sys_clk_i);
    system_wake_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk({14'h0000, sleep_commanded_o, clock_run_o}, 16'h0001);
  endtask : t_sleep

  task automatic t_inhibit();
    disable_mode_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk({15'h0000, inhibit_output_o}, 16'h0001);
    wr(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, 16'h0000);
    repeat (2) @(negedge sys_clk_i);
    chk({14'h0000, inhibit_output_o, clock_run_o}, 16'h0000);
    clk_needed_i = 2'h2;
    disable_mode_i = 1'b0;
    inhibit_request_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk({14'h0000, inhibit_output_o, clock_run_o}, 16'h0003);
  endtask : t_inhibit

  // second reset in mid-run with every strap inverted
  task automatic t_restrap();
    @(negedge sys_clk_i);
    straps = 7'h2A;
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(cfg_vec, 16'h5040);
    chk({14'h0000, port_enable_o}, 16'h0002);
    rd(PCFC_PHYAD_PORT_ZERO, PCFC_REG_COMMON_CFG, rdat);
    chk(rdat, 16'h5040);
  endtask : t_restrap

  // two reset cycles are enough: the strap synchroniser settles under reset
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    t_reset();
    t_counters();
    t_saturate();
    t_config();
    t_port_one();
    t_sleep();
    t_inhibit();
    t_restrap();
    print_verdict();
  end
endmodule : pcfc_regs_tb
